// ==== pmicsw_crc8.sv ====
// one byte step of the crc-8 over the link bytes
`timescale 1ns/1ps
module pmicsw_crc8 (
   pmicsw_crc_if.eng c
);
   // msb first, one byte per call of the running value
   always_comb
   begin
      logic [7:0] r;
      r = c.crc_in ^ c.data_in;
      for (int i = 0; i < 8; i++)
      begin
         r = r[7] ? ((r << 1) ^ pmicsw_pkg::CRC_POLY) : (r << 1);
      end
      c.crc_out = r;
   end
endmodule : pmicsw_crc8

// ==== pmicsw_crc_if.sv ====
// carrier between the target and its crc engine
`timescale 1ns/1ps
interface pmicsw_crc_if;
   logic [7:0] crc_in;
   logic [7:0] data_in;
   logic [7:0] crc_out;
   modport user (output crc_in, output data_in, input crc_out);
   modport eng  (input crc_in, input data_in, output crc_out);
endinterface : pmicsw_crc_if

// ==== pmicsw_host.sv ====
// host-side i2c controller model that drives the link pins
`timescale 1ns/1ps
module pmicsw_host (
   output logic scl,
   output logic sda_drv,
   input  wire  sda
);
   // --------------------------------------------------------------
   // bus timing: 400 ns per bit, data moved mid-low
   // --------------------------------------------------------------
   // idle bus: both lines released to the pull-up
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // start or repeated start; sda only falls while scl is high
   task automatic start();
      sda_drv = 1'b1;
      #100 scl = 1'b1;
      #100 sda_drv = 1'b0;
      #100 scl = 1'b0;
      #100;
   endtask : start

   task automatic stop();
      sda_drv = 1'b0;
      #100 scl = 1'b1;
      #100 sda_drv = 1'b1;
      #100;
   endtask : stop

   // one clock: high and low of 200 ns each, well above three sys_clk
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      #100 scl = 1'b1;
      #100 r = sda;
      #100 scl = 0;
      #100;
   endtask : bit_io

   // n data bits msb first, then the ninth clock only for a whole byte
   task automatic byte_io(input logic [7:0] d, input int n, input logic ab, output logic [7:0] r, output logic k);
      for (int i = 7; i > 7 - n; i--) bit_io(d[i], r[i]);
      if (n == 8) bit_io(ab, k);
   endtask : byte_io
endmodule : pmicsw_host

// ==== pmicsw_pkg.sv ====
// constants shared by the pmic secure i2c target modules
package pmicsw_pkg;
   // --------------------------------------------------------------
   // link and timing
   // --------------------------------------------------------------
   localparam logic [6:0] ADDR_BASE   = 7'h08;     // fused field adds onto this
   localparam logic [6:0] ADDR_TEST   = 7'h08;     // fixed address in test mode
   localparam int         SCL_MAX_KHZ = 3400;      // fastest scl served
   localparam int         CLK_HZ      = 20000000;
   localparam int         TIMEOUT_MS  = 10;
   localparam int         TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam logic [3:0] ACK_SLOT    = 4'h8;      // bit count of the ninth clock
   localparam logic [3:0] LAST_BIT    = 4'h7;

   // --------------------------------------------------------------
   // crc and random code
   // --------------------------------------------------------------
   localparam logic [7:0] CRC_POLY  = 8'h1D;       // 0x11D with x^8 implied
   localparam logic [7:0] CRC_INIT  = 8'hFF;
   localparam logic [7:0] LFSR_SEED = 8'hA5;

   // --------------------------------------------------------------
   // register offsets, fields and reset values
   // --------------------------------------------------------------
   localparam logic [7:0] REG_ST_OV    = 8'h01;
   localparam logic [7:0] REG_ST_UV    = 8'h02;
   localparam logic [7:0] REG_ST_RUN   = 8'h03;
   localparam logic [7:0] REG_SO_FLAGS = 8'h04;
   localparam logic [7:0] REG_CTRL1    = 8'h05;
   localparam logic [7:0] REG_VMON     = 8'h06;
   localparam logic [7:0] REG_INT_STAT = 8'h07;
   localparam logic [7:0] REG_INT_MASK = 8'h08;
   localparam logic [7:0] REG_CODE_OUT = 8'h09;
   localparam logic [7:0] REG_CODE_RET = 8'h0A;
   localparam int         CTRL_THERM   = 0;
   localparam int         CTRL_WDI_TYP = 1;
   localparam int         CTRL_OVLO    = 2;
   localparam int         CTRL_OVSD    = 3;
   localparam int         CTRL_WD      = 4;
   localparam int         CTRL_WD_SBY  = 5;
   localparam int         CTRL_WDI_SBY = 6;
   localparam int         CTRL_SEC     = 7;
   localparam logic [7:0] CTRL_RST     = 8'hFD;
   localparam logic [6:0] VMON_RST     = 7'h7F;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_WCRC, ST_RDATA, ST_RCRC, ST_SKIP} pmicsw_state_t;
endpackage : pmicsw_pkg

// ==== pmicsw_sync.sv ====
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pmicsw_sync #(
   parameter int W = 1
) (
   input  logic         sys_clk,
   input  logic         rst,
   input  logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : pmicsw_sync

// ==== pmicsw_top.sv ====
// i2c target with crc check and secure write for the pmic
`timescale 1ns/1ps
//
// Contract
// R1: act only as i2c target, serve scl up to 3.4 MHz.
// R2: address is 0x08 plus the 3-bit fused field, up to 0x0F.
// R3: take a byte only after its eighth bit; drop shorter tails.
// R4: seven bits only: no register write and no acknowledge.
// R5: fused crc enable turns crc checking off or on.
// R6: with crc on, compute crc per transaction and compare with sent byte.
// R7: on crc mismatch drop the write, set crc flag, pull irq unless masked.
// R8: crc-8 polynomial 0x11D, preset 0xFF at each transaction start.
// R9: fused secure enable: 0 plain writes act, 1 needs the handshake; code also drops the handshake while CTRL1 bit 7 is zero.
// R10: protected write waits, random code loaded; host returns it.
// R11: returned code equal: commit pending write, clear code registers.
// R12: returned code differs: drop pending write, clear code registers.
// R13: other command while pending: abandon it, run new command normally.
// R14: no return within 10 ms: cancel pending write.
// R15: self-test over/undervoltage flags are protected, write one clears.
// R16: writing one to protected launch bit starts a self-test.
// R17: five safety-output fault flags are protected, write one clears.
// R18: writing zero disables watchdog counter, standby counter, standby input.
// R19: watchdog input reaction: 0 soft reset, 1 hard reset.
// R20: writing zero to shutdown bit leaves input overvoltage as interrupt only.
// R21: one protected voltage monitor enable per regulator; zero disables.
// R22: writing zero to thermal enable stops thermal detection.
// R23: test mode input high: answer only at fixed address 0x08.
// R24: test mode without power-up event bypasses crc and secure write.
// R25: safety flag clears need the full handshake when secure write is on.
// R26: write crc follows data over addr, reg, data; read crc follows data.
module pmicsw_top #(
   parameter int TIMEOUT_CYC = pmicsw_pkg::TIMEOUT_CYC
) (
   input  logic       sys_clk,
   input  logic       rst,
   input  logic       scl_in,
   input  logic       sda_in,
   output logic       sda_out,
   output logic       sda_oe,
   input  logic [2:0] fuse_addr,
   input  logic       fuse_crc_en,
   input  logic       fuse_secure_en,
   input  logic       test_config_mode_in,
   input  logic       power_up_active,
   input  logic [6:0] selftest_ov_set,
   input  logic [6:0] selftest_uv_set,
   input  logic [4:0] safeout_set,
   output logic [6:0] selftest_overvolt_flags,
   output logic [6:0] selftest_undervolt_flags,
   output logic       self_test_launch,
   output logic [4:0] safeout_flags,
   output logic       thermal_monitor_enable,
   output logic       wdog_input_reset_type,
   output logic       input_overvolt_lockout_enable,
   output logic       input_overvolt_shutdown_enable,
   output logic       wdog_counter_enable,
   output logic       wdog_counter_standby_enable,
   output logic       wdog_input_standby_monitor,
   output logic [6:0] voltage_monitor_enable,
   output logic       irq_out_n
);
   localparam logic [17:0] TMO_LAST = 18'(TIMEOUT_CYC - 1);

   pmicsw_pkg::pmicsw_state_t st_q;
   logic [8:0]  pins_s;
   logic        scl_s, sda_s, scl_p_q, sda_p_q, tm_s, pu_s;
   logic        rise, fall, start, stop, byte_done, tx_mode;
   logic [3:0]  cnt_q;
   logic [6:0]  sh_q;
   logic [7:0]  b, tx_q, ptr_q, wdat_q, wcrc_q, crc_q, rd_val, lfsr_q;
   logic        ack_q, have_d_q, have_c_q, sda_oe_q, irq_q;
   logic [6:0]  my_addr, ov_q, uv_q, vmon_q;
   logic        crc_on, sec_on, bypass, commit, crc_ok, wr_ok, crc_bad;
   logic        prot, chk, chk_ok, rd_cmd, ap_v;
   logic [7:0]  ap_reg, ap_data, code_q, ret_q, pend_reg_q, pend_data_q, ctrl_q;
   logic        pend_q, launch_q, crc_flag_q, crc_mask_q;
   logic [4:0]  so_q;
   logic [17:0] tmr_q;
   pmicsw_crc_if crc_bus ();

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // --------------------------------------------------------------
   // pin sampling and bus conditions
   // --------------------------------------------------------------
   // every link, mode, power-up and fuse pin passes two flops; 20 MHz gives about three samples per
   // scl high phase at the fastest rate, so glitches shorter than that slip
   // link lines pass inverted so cleared stages read as an idle bus, no false edge
   pmicsw_sync #(.W(9)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       ({~scl_in, ~sda_in, test_config_mode_in, power_up_active, fuse_crc_en, fuse_secure_en, fuse_addr}),
      .q       (pins_s)
   );
   assign scl_s = ~pins_s[8];
   assign sda_s = ~pins_s[7];
   assign tm_s  = pins_s[6];
   assign pu_s  = pins_s[5];

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // edges of the sampled link clock, target role only
   assign rise  = scl_s & ~scl_p_q; // R1
   assign fall  = ~scl_s & scl_p_q;
   assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // mode selection from fuses and test input
   assign bypass  = tm_s & ~pu_s; // R24
   assign crc_on  = pins_s[4] & ~bypass; // R5
   assign sec_on  = pins_s[3] & ctrl_q[pmicsw_pkg::CTRL_SEC] & ~bypass; // R9
   assign my_addr = tm_s ? pmicsw_pkg::ADDR_TEST : pmicsw_pkg::ADDR_BASE + {4'h0, pins_s[2:0]}; // R2 R23

   assign tx_mode   = (st_q == pmicsw_pkg::ST_RDATA) || (st_q == pmicsw_pkg::ST_RCRC);
   assign b         = {sh_q, sda_s};
   assign byte_done = rise && cnt_q == pmicsw_pkg::LAST_BIT && !tx_mode; // R3

   // running crc over bytes as they pass, in either direction
   assign crc_bus.crc_in  = crc_q;
   assign crc_bus.data_in = tx_mode ? tx_q : b; // R26
   pmicsw_crc8 u_crc (.c(crc_bus.eng));

   // --------------------------------------------------------------
   // byte engine
   // --------------------------------------------------------------
   // start or repeated start presets the crc; a seven-bit byte still reaches the handler on the stop's scl rise
   always_ff @(posedge sys_clk)
   begin
      if (rst || start || stop)
      begin
         st_q     <= start ? pmicsw_pkg::ST_ADDR : pmicsw_pkg::ST_IDLE;
         cnt_q    <= 4'h0;
         ack_q    <= 1'b0;
         have_d_q <= 1'b0;
         have_c_q <= 1'b0;
         crc_q    <= pmicsw_pkg::CRC_INIT; // R8
         if (rst)
         begin
            sh_q   <= 7'h00;
            tx_q   <= 8'h00;
            ptr_q  <= 8'h00;
            wdat_q <= 8'h00;
            wcrc_q <= 8'h00;
         end
      end
      else if (rise && cnt_q == pmicsw_pkg::ACK_SLOT)
      begin
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
         // host nack ends the read; after data, crc goes out when enabled;
         // our own address acknowledge (sda still driven) is no host answer
         if (tx_mode && !sda_oe_q && sda_s)
            st_q <= pmicsw_pkg::ST_SKIP;
         else if (st_q == pmicsw_pkg::ST_RDATA && !sda_oe_q && crc_on)
         begin
            st_q <= pmicsw_pkg::ST_RCRC;
            tx_q <= crc_q; // R26
         end
         else if (tx_mode && !sda_oe_q)
            st_q <= pmicsw_pkg::ST_SKIP;
      end
      else if (rise && st_q != pmicsw_pkg::ST_IDLE)
      begin
         cnt_q <= cnt_q + 4'h1;
         sh_q  <= b[6:0];
         if (rise && cnt_q == pmicsw_pkg::LAST_BIT && st_q == pmicsw_pkg::ST_RDATA)
            crc_q <= crc_bus.crc_out;
         if (byte_done)
         begin
            unique case (st_q)
               pmicsw_pkg::ST_ADDR:
               begin
                  crc_q <= crc_bus.crc_out;
                  ack_q <= b[7:1] == my_addr;
                  if (b[7:1] != my_addr)
                     st_q <= pmicsw_pkg::ST_SKIP;
                  else if (b[0])
                  begin
                     st_q <= pmicsw_pkg::ST_RDATA;
                     tx_q <= rd_val;
                  end
                  else
                     st_q <= pmicsw_pkg::ST_REG;
               end
               pmicsw_pkg::ST_REG:
               begin
                  crc_q <= crc_bus.crc_out;
                  ptr_q <= b;
                  ack_q <= 1'b1;
                  st_q  <= pmicsw_pkg::ST_WDATA;
               end
               pmicsw_pkg::ST_WDATA:
               begin
                  crc_q    <= crc_bus.crc_out;
                  wdat_q   <= b;
                  ack_q    <= 1'b1;
                  st_q     <= pmicsw_pkg::ST_WCRC;
               end
               pmicsw_pkg::ST_WCRC:
               begin
                  wcrc_q   <= b;
                  ack_q    <= 1'b1;
                  st_q     <= pmicsw_pkg::ST_SKIP;
               end
               default:
                  ack_q <= 1'b0;
            endcase
         end
      end
      else if (fall && cnt_q == pmicsw_pkg::ACK_SLOT)
      begin
         // a byte counts once scl falls after its eighth bit; a stop right
         // after seven bits raises an eighth rise but never this fall
         have_d_q <= have_d_q | (st_q == pmicsw_pkg::ST_WCRC); // R3 R4
         have_c_q <= have_c_q | (st_q == pmicsw_pkg::ST_SKIP && have_d_q); // R3
      end
   end

   // sda is driven on scl low: ack in the ninth slot, data bits when sending
   always_ff @(posedge sys_clk)
   begin
      if (rst || start || stop)
         sda_oe_q <= 1'b0;
      else if (fall)
      begin
         if (cnt_q == pmicsw_pkg::ACK_SLOT)
            sda_oe_q <= ack_q; // R4
         else if (tx_mode)
            sda_oe_q <= ~tx_q[3'h7 - cnt_q[2:0]];
         else
            sda_oe_q <= 1'b0;
      end
   end
   assign sda_oe  = sda_oe_q;
   assign sda_out = 1'b0;

   seven_bits_a: assert property (fall && cnt_q != pmicsw_pkg::ACK_SLOT && !tx_mode |=> !sda_oe_q) // R4
      else $error("sda driven outside the acknowledge slot");
   addr_miss_a: assert property (byte_done && st_q == pmicsw_pkg::ST_ADDR && b[7:1] != my_addr |=> !ack_q) // R2
      else $error("acknowledge given to a foreign address");

   // --------------------------------------------------------------
   // write commit, crc check and secure handshake
   // --------------------------------------------------------------
   assign commit  = (start || stop) && have_d_q;
   assign crc_ok  = !crc_on || (have_c_q && wcrc_q == crc_q); // R6
   assign wr_ok   = commit && crc_ok;
   assign crc_bad = commit && !crc_ok; // R7
   assign prot    = ptr_q >= pmicsw_pkg::REG_ST_OV && ptr_q <= pmicsw_pkg::REG_VMON;
   assign chk     = wr_ok && pend_q && ptr_q == pmicsw_pkg::REG_CODE_RET;
   assign chk_ok  = chk && wdat_q == code_q; // R11
   assign rd_cmd  = byte_done && st_q == pmicsw_pkg::ST_ADDR && b[7:1] == my_addr && b[0];

   // the write reaching the registers, direct or released by the handshake
   always_comb
   begin
      ap_v    = 1'b0;
      ap_reg  = ptr_q;
      ap_data = wdat_q;
      if (chk_ok)
      begin
         ap_v    = 1'b1;
         ap_reg  = pend_reg_q;
         ap_data = pend_data_q;
      end
      else if (wr_ok && !(prot && sec_on) && ptr_q != pmicsw_pkg::REG_CODE_RET)
         ap_v = 1'b1;
   end

   // free-running lfsr; never zero, so a cleared code is never a live one
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         lfsr_q <= pmicsw_pkg::LFSR_SEED;
      else
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
   end

   // pending protected write, its code and its timer
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pend_q      <= 1'b0;
         pend_reg_q  <= 8'h00;
         pend_data_q <= 8'h00;
         code_q      <= 8'h00;
         ret_q       <= 8'h00;
         tmr_q       <= 18'h00000;
      end
      else if (chk)
      begin
         pend_q <= 1'b0; // R11 R12
         code_q <= 8'h00;
         ret_q  <= 8'h00;
      end
      else if (wr_ok && prot && sec_on)
      begin
         pend_q      <= 1'b1; // R10 R25
         pend_reg_q  <= ptr_q;
         pend_data_q <= wdat_q;
         code_q      <= lfsr_q;
         ret_q       <= 8'h00;
         tmr_q       <= 18'h00000;
      end
      else if (pend_q && (wr_ok || (rd_cmd && ptr_q != pmicsw_pkg::REG_CODE_OUT) || tmr_q == TMO_LAST))
      begin
         pend_q <= 1'b0; // R13 R14
         code_q <= 8'h00;
         ret_q  <= 8'h00;
      end
      else
      begin
         if (wr_ok && ptr_q == pmicsw_pkg::REG_CODE_RET)
            ret_q <= wdat_q;
         if (pend_q)
            tmr_q <= tmr_q + 18'h00001;
      end
   end

   sequence s_protected_write;
      wr_ok && prot && sec_on;
   endsequence
   pend_code_a: assert property (s_protected_write |=> pend_q && code_q != 8'h00 && tmr_q == 18'h00000) // R10
      else $error("protected write did not start the handshake");
   chk_clear_a: assert property (chk |=> !pend_q && code_q == 8'h00 && ret_q == 8'h00) // R12
      else $error("code registers not cleared after return");
   chk_commit_a: assert property (chk_ok && pend_reg_q == pmicsw_pkg::REG_CTRL1 |=> ctrl_q == $past(pend_data_q)) // R11
      else $error("matching code did not commit the pending write");
   cancel_new_a: assert property (pend_q && wr_ok && !prot && ptr_q != pmicsw_pkg::REG_CODE_RET |-> ap_v ##1 !pend_q) // R13
      else $error("other command did not cancel and execute");
   timeout_a: assert property (pend_q && tmr_q == TMO_LAST && !wr_ok |=> !pend_q) // R14
      else $error("pending write outlived its timeout");
   crc_drop_a: assert property (crc_bad |-> !ap_v ##1 crc_flag_q) // R7
      else $error("crc fault did not drop the write and flag it");
   crc_off_a: assert property (commit && !crc_on |-> !crc_bad) // R5
      else $error("crc fault raised with checking off");

   // --------------------------------------------------------------
   // register file
   // --------------------------------------------------------------
   // hardware sets win over a write-one clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ov_q       <= 7'h00;
         uv_q       <= 7'h00;
         so_q       <= 5'h00;
         launch_q   <= 1'b0;
         ctrl_q     <= pmicsw_pkg::CTRL_RST;
         vmon_q     <= pmicsw_pkg::VMON_RST;
         crc_flag_q <= 1'b0;
         crc_mask_q <= 1'b0;
         irq_q      <= 1'b1;
      end
      else
      begin
         ov_q     <= (ov_q & ~((ap_v && ap_reg == pmicsw_pkg::REG_ST_OV) ? ap_data[6:0] : 7'h00)) | selftest_ov_set; // R15
         uv_q     <= (uv_q & ~((ap_v && ap_reg == pmicsw_pkg::REG_ST_UV) ? ap_data[6:0] : 7'h00)) | selftest_uv_set; // R15
         so_q     <= (so_q & ~((ap_v && ap_reg == pmicsw_pkg::REG_SO_FLAGS) ? ap_data[4:0] : 5'h00)) | safeout_set; // R17
         launch_q <= ap_v && ap_reg == pmicsw_pkg::REG_ST_RUN && ap_data[0]; // R16
         if (ap_v && ap_reg == pmicsw_pkg::REG_CTRL1)
            ctrl_q <= ap_data; // R18 R19 R20 R22
         if (ap_v && ap_reg == pmicsw_pkg::REG_VMON)
            vmon_q <= ap_data[6:0]; // R21
         crc_flag_q <= (crc_flag_q & ~(ap_v && ap_reg == pmicsw_pkg::REG_INT_STAT && ap_data[0])) | crc_bad; // R7
         if (ap_v && ap_reg == pmicsw_pkg::REG_INT_MASK)
            crc_mask_q <= ap_data[0];
         irq_q <= ~(crc_flag_q & ~crc_mask_q); // R7
      end
   end

   // read data for the pointed register; unmapped offsets read zero
   always_comb
   begin
      unique case (ptr_q)
         pmicsw_pkg::REG_ST_OV:    rd_val = {1'b0, ov_q};
         pmicsw_pkg::REG_ST_UV:    rd_val = {1'b0, uv_q};
         pmicsw_pkg::REG_SO_FLAGS: rd_val = {3'h0, so_q};
         pmicsw_pkg::REG_CTRL1:    rd_val = ctrl_q;
         pmicsw_pkg::REG_VMON:     rd_val = {1'b0, vmon_q};
         pmicsw_pkg::REG_INT_STAT: rd_val = {7'h00, crc_flag_q};
         pmicsw_pkg::REG_INT_MASK: rd_val = {7'h00, crc_mask_q};
         pmicsw_pkg::REG_CODE_OUT: rd_val = code_q;
         pmicsw_pkg::REG_CODE_RET: rd_val = ret_q;
         default:                  rd_val = 8'h00;
      endcase
   end

   launch_a: assert property (ap_v && ap_reg == pmicsw_pkg::REG_ST_RUN && ap_data[0] |=> self_test_launch ##1 !self_test_launch) // R16
      else $error("self-test launch is not a single pulse");
   irq_mask_a: assert property (crc_bad && !crc_mask_q |=> ##1 !irq_out_n) // R7
      else $error("crc fault did not pull the interrupt pin");

   // outputs straight from the register flops
   assign selftest_overvolt_flags        = ov_q;
   assign selftest_undervolt_flags       = uv_q;
   assign safeout_flags                  = so_q;
   assign self_test_launch               = launch_q;
   assign thermal_monitor_enable         = ctrl_q[pmicsw_pkg::CTRL_THERM];
   assign wdog_input_reset_type          = ctrl_q[pmicsw_pkg::CTRL_WDI_TYP];
   assign input_overvolt_lockout_enable  = ctrl_q[pmicsw_pkg::CTRL_OVLO];
   assign input_overvolt_shutdown_enable = ctrl_q[pmicsw_pkg::CTRL_OVSD];
   assign wdog_counter_enable            = ctrl_q[pmicsw_pkg::CTRL_WD];
   assign wdog_counter_standby_enable    = ctrl_q[pmicsw_pkg::CTRL_WD_SBY];
   assign wdog_input_standby_monitor     = ctrl_q[pmicsw_pkg::CTRL_WDI_SBY];
   assign voltage_monitor_enable         = vmon_q;
   assign irq_out_n                      = irq_q;
endmodule : pmicsw_top

// ==== tb.sv ====
// self-checking bench for the pmic secure i2c target
`timescale 1ns/1ps
module tb;
   logic       sys_clk = 1'b0, rst = 1'b1, scl, sda_drv, sda_oe, nak, power_up_active = 1'b0;
   logic       fuse_crc_en = 1'b1, fuse_secure_en = 1'b1, test_config_mode_in = 1'b0, crc_on = 1'b1;
   logic [2:0] fuse_addr = 3'h5;
   logic [6:0] selftest_ov_set = '0, selftest_uv_set = '0, selftest_overvolt_flags, selftest_undervolt_flags;
   logic [6:0] voltage_monitor_enable;
   logic [4:0] safeout_set = '0, safeout_flags;
   logic       self_test_launch, thermal_monitor_enable, wdog_input_reset_type, irq_out_n;
   logic       input_overvolt_lockout_enable, input_overvolt_shutdown_enable, wdog_counter_enable;
   logic       wdog_counter_standby_enable, wdog_input_standby_monitor;
   logic [7:0] rd_q, code_q;
   int         error_cnt = 0, tests_run = 0;
   // open drain: the pull-up wins unless someone pulls low
   wire        sda_w = sda_drv & ~sda_oe;
   wire  [7:0] ctl = {1'b0, wdog_input_standby_monitor, wdog_counter_standby_enable, wdog_counter_enable,
                      input_overvolt_shutdown_enable, input_overvolt_lockout_enable, wdog_input_reset_type,
                      thermal_monitor_enable};

   always #25 sys_clk = ~sys_clk;

   // timeout shortened so the expiry case stays cheap to run
   pmicsw_top #(.TIMEOUT_CYC(2000)) uut (.*, .scl_in(scl), .sda_in(sda_w), .sda_out());
   pmicsw_host h (.scl(scl), .sda_drv(sda_drv), .sda(sda_w));

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h1D : {c[6:0], 1'b0};
      return c;
   endfunction : crc8

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      if (n > 0) #5;
   endtask : idle

   // write with crc over address, register and data; bad flips crc bit 0
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, input logic bad);
      logic [7:0] c, x;
      logic       k;
      c = crc8(crc8(crc8(8'hFF, {a, 1'b0}), r), d) ^ {7'h0, bad};
      h.start();
      h.byte_io({a, 1'b0}, 8, 1'b1, x, nak);
      h.byte_io(r, 8, 1'b1, x, k);
      h.byte_io(d, 8, 1'b1, x, k);
      if (crc_on) h.byte_io(c, 8, 1'b1, x, k);
      h.stop();
      idle(6);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] r);
      logic [7:0] c, x;
      logic       k;
      h.start();
      h.byte_io({a, 1'b0}, 8, 1'b1, x, k);
      h.byte_io(r, 8, 1'b1, x, k);
      h.start();
      h.byte_io({a, 1'b1}, 8, 1'b1, x, k);
      h.byte_io(8'hFF, 8, ~crc_on, rd_q, k);
      if (crc_on) h.byte_io(8'hFF, 8, 1'b1, c, k);
      h.stop();
      idle(4);
      if (crc_on) chk(c, crc8(crc8(8'hFF, {a, 1'b1}), rd_q));
   endtask : rd

   // protected write, code fetch, optional pause or other command, code return
   task automatic sec(input logic [7:0] d, input logic [7:0] dx, input int gap, input logic cut);
      wr(7'h0D, pmicsw_pkg::REG_CTRL1, d, 1'b0);
      rd(7'h0D, pmicsw_pkg::REG_CODE_OUT);
      code_q = rd_q;
      idle(gap);
      if (cut) wr(7'h0D, pmicsw_pkg::REG_INT_MASK, 8'h00, 1'b0);
      wr(7'h0D, pmicsw_pkg::REG_CODE_RET, code_q ^ dx, 1'b0);
   endtask : sec

   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // --------------------------------------------------------------
   // tests
   // --------------------------------------------------------------
   initial
   begin
      idle(8);
      rst = 1'b0;
      idle(4);
      chk(ctl, 8'h7D);
      chk({1'b0, voltage_monitor_enable}, 8'h7F);
      wr(7'h08, pmicsw_pkg::REG_INT_MASK, 8'h01, 1'b0);
      chk({7'h0, nak}, 8'h01);
      sec(8'h80, 8'h00, 0, 1'b0);
      chk({7'h0, nak}, 8'h00);
      chk({7'h0, code_q == 8'h00}, 8'h00);
      chk(ctl, 8'h00);
      rd(7'h0D, pmicsw_pkg::REG_CODE_OUT);
      chk(rd_q, 8'h00);
      sec(8'hFD, 8'h01, 0, 1'b0);
      chk(ctl, 8'h00);
      sec(8'hFD, 8'h00, 2100, 1'b0);
      chk(ctl, 8'h00);
      sec(8'hFD, 8'h00, 0, 1'b1);
      chk(ctl, 8'h00);
      // corrupted crc: write dropped, interrupt raised, then cleared
      wr(7'h0D, pmicsw_pkg::REG_CTRL1, 8'hFD, 1'b1);
      chk({7'h0, irq_out_n}, 8'h00);
      wr(7'h0D, pmicsw_pkg::REG_INT_STAT, 8'h01, 1'b0);
      chk({7'h0, irq_out_n}, 8'h01);
      // fuses off: plain write lands, a seven-bit byte does nothing
      {fuse_crc_en, fuse_secure_en, crc_on} = 3'h0;
      wr(7'h0D, pmicsw_pkg::REG_CTRL1, 8'hFD, 1'b0);
      chk(ctl, 8'h7D);
      h.start();
      h.byte_io(8'h1A, 8, 1'b1, rd_q, nak);
      h.byte_io(pmicsw_pkg::REG_CTRL1, 8, 1'b1, rd_q, nak);
      h.byte_io(8'h00, 7, 1'b1, rd_q, nak);
      h.stop();
      idle(6);
      chk(ctl, 8'h7D);
      // test mode: fixed address, checks bypassed
      {fuse_crc_en, fuse_secure_en, test_config_mode_in} = 3'h7;
      wr(7'h08, pmicsw_pkg::REG_CTRL1, 8'h80, 1'b0);
      chk({7'h0, nak}, 8'h00);
      chk(ctl, 8'h00);
      // set every overvoltage and safety-output flag, then clear some by plain write-one
      {selftest_ov_set, safeout_set} = 12'hFFF;
      idle(1);
      {selftest_ov_set, safeout_set} = 12'h000;
      wr(7'h08, pmicsw_pkg::REG_ST_OV, 8'h41, 1'b0);
      chk({1'b0, selftest_overvolt_flags}, 8'h3E);
      wr(7'h08, pmicsw_pkg::REG_SO_FLAGS, 8'h05, 1'b0);
      chk({3'h0, safeout_flags}, 8'h1A);
      summarize();
   end

   // watchdog: the sequence needs well under one millisecond
   initial
   begin
      #2000000;
      error_cnt++;
      summarize();
   end
endmodule : tb
